// File: sdfb_pkg.sv
// sdfb_pkg: shared constants and types of the diagnostic frame builder
// assumes one core clock domain; no software registers
package sdfb_pkg;

    // frame layout, in bytes; MAX_ENTRIES is an entry count, ENTRY_W and BODY_W are widths in bits
    localparam int TOTAL_MAX_BYTES = 96;
    localparam int STN_HDR_BYTES = 6;
    localparam int IDENT_POS = 6;
    localparam int IDENT_BYTES = 3;
    localparam int MODSTAT_BYTES = 8;
    localparam int ENTRY_BYTES = 3;
    localparam int BODY_BYTES = IDENT_BYTES + MODSTAT_BYTES;
    localparam int FIXED_BYTES = STN_HDR_BYTES + BODY_BYTES;
    localparam int MAX_ENTRIES = (TOTAL_MAX_BYTES - FIXED_BYTES) / ENTRY_BYTES;
    localparam int ENTRY_W = 8 * ENTRY_BYTES;
    localparam int BODY_W = 8 * BODY_BYTES;

    // third station status byte
    localparam int OVF_BIT = 7;
    localparam logic [7:0] STAT3_RST = 8'h00;

    // standard error type codes
    // (RULE_11) short-circuit code
    localparam logic [4:0] ERR_SHORT = 5'h01;
    // (RULE_12) supply band codes
    localparam logic [4:0] ERR_UNDERVOLT = 5'h02;
    localparam logic [4:0] ERR_OVERVOLT = 5'h03;
    // (RULE_13) output stage codes
    localparam logic [4:0] ERR_OVERLOAD = 5'h04;
    localparam logic [4:0] ERR_OVERTEMP = 5'h05;
    // (RULE_14) wire break code
    localparam logic [4:0] ERR_WIRE_BREAK = 5'h06;
    // (RULE_15) range limit codes
    localparam logic [4:0] ERR_OVERRANGE = 5'h07;
    localparam logic [4:0] ERR_UNDERRANGE = 5'h08;
    // (RULE_16) general fault code
    localparam logic [4:0] ERR_GENERAL = 5'h09;

    // fault kinds reported by the module side
    typedef enum logic [3:0] {
        KIND_SHORT = 4'h0,
        KIND_UNDERVOLT = 4'h1,
        KIND_OVERVOLT = 4'h2,
        KIND_OVERLOAD = 4'h3,
        KIND_OVERTEMP = 4'h4,
        KIND_WIRE_BREAK = 4'h5,
        KIND_OVERRANGE = 4'h6,
        KIND_UNDERRANGE = 4'h7,
        KIND_GENERAL = 4'h8
    } sdfb_kind_t;

    // controller states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CLR = 4'h2,
        ST_HDR = 4'h4,
        ST_ENT = 4'h8
    } sdfb_state_t;

    // memory read sub-phases
    localparam logic [1:0] PH_WAIT = 2'h0;
    localparam logic [1:0] PH_EVAL = 2'h1;
    localparam logic [1:0] PH_EMIT = 2'h2;

    // kind to error type; unknown kinds fall back to the general code
    function automatic logic [4:0] sdfb_err_code(input logic [3:0] kind);
        logic [4:0] code;
        code = ERR_GENERAL;
        case (kind)
            KIND_SHORT: code = ERR_SHORT;
            KIND_UNDERVOLT: code = ERR_UNDERVOLT;
            KIND_OVERVOLT: code = ERR_OVERVOLT;
            KIND_OVERLOAD: code = ERR_OVERLOAD;
            KIND_OVERTEMP: code = ERR_OVERTEMP;
            KIND_WIRE_BREAK: code = ERR_WIRE_BREAK;
            KIND_OVERRANGE: code = ERR_OVERRANGE;
            KIND_UNDERRANGE: code = ERR_UNDERRANGE;
            default: code = ERR_GENERAL;
        endcase
        return code;
    endfunction : sdfb_err_code

endpackage : sdfb_pkg

// File: sdfb_mem_if.sv
// sdfb_mem_if: port between the frame controller and its entry store
// assumes both ends on the same clock
`timescale 1ns/10ps
interface sdfb_mem_if #(
    parameter int W = 24,
    parameter int AW = 5
);
    logic we;
    logic [AW-1:0] waddr;
    logic [W-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [W-1:0] rdata;

    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : sdfb_mem_if

// File: sdfb_entry_mem.sv
// sdfb_entry_mem: pending channel entries, registered read
// assumes write and read addresses are valid each cycle
`timescale 1ns/10ps
module sdfb_entry_mem #(
    parameter int W = 24,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    sdfb_mem_if.store m
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] words;
        logic [W-1:0] rdata;
    } sdfb_mem_st_t;

    sdfb_mem_st_t mem_r;
    sdfb_mem_st_t mem_nxt;

    always_comb begin
        mem_nxt = mem_r;
        if (m.we) begin
            mem_nxt.words[m.waddr] = m.wdata;
        end
        mem_nxt.rdata = mem_r.words[m.raddr];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_r <= '0;
        end else begin
            mem_r <= mem_nxt;
        end
    end

    assign m.rdata = mem_r.rdata;
endmodule : sdfb_entry_mem

// File: sdfb_frame_builder.sv
// sdfb_frame_builder: builds slave diagnostics from the identifier block onward
// assumes all inputs come from logic on CORE_CLK
`timescale 1ns/10ps

// How it works
// (RULE_01) module status: 8 bytes after identifier block
// (RULE_02) channel entries follow module status directly
// (RULE_03) module status independent of channel entries
// (RULE_04) whole frame never exceeds 96 bytes
// (RULE_05) one entry per pending diagnostic, capped
// (RULE_06) all-channel fault reported once on channel 0
// (RULE_07) overflow sets station status 3 bit 7
// (RULE_08) held-back entries kept, promoted as others clear
// (RULE_09) overflow bit clears once everything fits
// (RULE_10) master enables diagnostic interrupt per module; this builder has no interrupt enable
// (RULE_11) short-circuit uses error type 00001
// (RULE_12) undervoltage 00010, overvoltage 00011
// (RULE_13) overload 00100, overtemperature 00101
// (RULE_14) any wire break uses 00110
// (RULE_15) overrange 00111, underrange 01000
// (RULE_16) general fault uses 01001
// (RULE_17) 5-bit type, never 0 or 10-15
// (RULE_18) promotion follows order of arrival
// (RULE_19) station status 3 bits 0-6 zero
// (RULE_20) identifier block at byte 6, 3 bytes
module sdfb_frame_builder #(
    parameter int DEPTH = 32
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic DIAG_VALID,
    output logic DIAG_READY,
    input wire logic DIAG_CLEAR,
    input wire logic [7:0] DIAG_SLOT,
    input wire logic [7:0] DIAG_CHAN,
    input wire logic DIAG_ALL_CH,
    input wire logic [3:0] DIAG_KIND,
    input wire logic [23:0] IDENT_DIAG,
    input wire logic [63:0] MOD_STATUS,
    input wire logic FRAME_REQ,
    output logic FRAME_READY,
    output logic [7:0] FRAME_DATA,
    output logic FRAME_VALID,
    output logic FRAME_LAST,
    output logic [7:0] FRAME_LEN,
    output logic [7:0] STATION_STAT3,
    output logic [7:0] PEND_COUNT
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || DEPTH > 128 || (1 << PW) != DEPTH || DEPTH <= sdfb_pkg::MAX_ENTRIES) begin : g_bad_depth
        $error("DEPTH must be a power of two above the entry cap and at most 128");
    end

    localparam logic [PW:0] ONE = (PW+1)'(1);
    localparam logic [PW:0] MAX_C = (PW+1)'(sdfb_pkg::MAX_ENTRIES);
    localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
    localparam logic [3:0] BODY_LAST = 4'(sdfb_pkg::BODY_BYTES - 1);
    localparam logic [1:0] ENT_LAST = 2'(sdfb_pkg::ENTRY_BYTES - 1);

    typedef struct packed {
        sdfb_pkg::sdfb_state_t st;
        logic [1:0] ph;
        logic [PW:0] head;
        logic [PW:0] tail;
        logic [PW-1:0] ptr;
        logic [PW:0] scanned;
        logic [PW:0] pend;
        logic [PW:0] nfrm;
        logic [PW:0] emitted;
        logic [DEPTH-1:0] vld;
        logic [1:0] bcnt;
        logic [3:0] bidx;
        logic [sdfb_pkg::BODY_W-1:0] body;
        logic [sdfb_pkg::ENTRY_W-1:0] key;
        logic [sdfb_pkg::ENTRY_W-1:0] ent;
        logic [7:0] dout;
        logic dval;
        logic dlast;
        logic [7:0] len;
        logic [7:0] stat3;
    } sdfb_st_t;

    sdfb_st_t r;
    sdfb_st_t n;

    sdfb_mem_if #(.W(sdfb_pkg::ENTRY_W), .AW(PW)) mif ();

    sdfb_entry_mem #(.W(sdfb_pkg::ENTRY_W), .DEPTH(DEPTH)) u_mem (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .m(mif.store)
    );

    logic full;
    logic take;
    logic [sdfb_pkg::ENTRY_W-1:0] word;
    logic [7:0] chan;

    // (RULE_06) all-channel fault folded to channel 0
    assign chan = DIAG_ALL_CH ? 8'h00 : DIAG_CHAN;
    // (RULE_17) five-bit type, reserved codes unreachable
    assign word = {DIAG_SLOT, chan, 3'h0, sdfb_pkg::sdfb_err_code(DIAG_KIND)};

    assign full = (r.tail - r.head) == DEPTH_C;
    assign FRAME_READY = (r.st == sdfb_pkg::ST_IDLE);
    assign DIAG_READY = (r.st == sdfb_pkg::ST_IDLE) && !FRAME_REQ && (DIAG_CLEAR || !full);
    assign take = DIAG_VALID && DIAG_READY;
    assign mif.raddr = r.ptr;

    always_comb begin
        n = r;
        n.dval = 1'b0;
        n.dlast = 1'b0;
        mif.we = 1'b0;
        mif.waddr = r.tail[PW-1:0];
        mif.wdata = word;
        // (RULE_07) overflow flag while entries held back
        // (RULE_09) drops once all pending fit
        // (RULE_19) remaining bits stay zero
        n.stat3 = sdfb_pkg::STAT3_RST;
        n.stat3[sdfb_pkg::OVF_BIT] = (r.pend > MAX_C);
        case (r.st)
            sdfb_pkg::ST_IDLE: begin
                if (FRAME_REQ) begin
                    // (RULE_03) module status taken as given
                    // (RULE_20) identifier block leads the body
                    n.body = {IDENT_DIAG, MOD_STATUS};
                    // (RULE_04) entry count capped by total length
                    // (RULE_05) one entry per pending diagnostic
                    n.nfrm = (r.pend > MAX_C) ? MAX_C : r.pend;
                    n.len = 8'(sdfb_pkg::FIXED_BYTES) + 8'(sdfb_pkg::ENTRY_BYTES) * 8'(n.nfrm);
                    n.bidx = 4'h0;
                    n.st = sdfb_pkg::ST_HDR;
                end else if (take && DIAG_CLEAR) begin
                    n.key = word;
                    n.ptr = r.head[PW-1:0];
                    n.scanned = '0;
                    n.ph = sdfb_pkg::PH_WAIT;
                    n.st = sdfb_pkg::ST_CLR;
                end else if (take) begin
                    // (RULE_08) every raised entry kept in store
                    mif.we = 1'b1;
                    n.vld[r.tail[PW-1:0]] = 1'b1;
                    n.tail = r.tail + ONE;
                    n.pend = r.pend + ONE;
                end
                if (n.st == sdfb_pkg::ST_IDLE && r.head != r.tail && !r.vld[r.head[PW-1:0]]) begin
                    n.head = r.head + ONE;
                end
            end
            sdfb_pkg::ST_CLR: begin
                if (r.ph == sdfb_pkg::PH_WAIT) begin
                    n.ph = sdfb_pkg::PH_EVAL;
                end else if (r.vld[r.ptr] && mif.rdata == r.key) begin
                    // (RULE_08) freed slot lets next entry move up
                    n.vld[r.ptr] = 1'b0;
                    n.pend = r.pend - ONE;
                    n.st = sdfb_pkg::ST_IDLE;
                end else if (r.scanned == DEPTH_C - ONE) begin
                    n.st = sdfb_pkg::ST_IDLE;
                end else begin
                    n.ptr = r.ptr + 1'b1;
                    n.scanned = r.scanned + ONE;
                    n.ph = sdfb_pkg::PH_WAIT;
                end
            end
            sdfb_pkg::ST_HDR: begin
                // (RULE_01) 3 identifier then 8 status bytes
                n.dout = r.body[sdfb_pkg::BODY_W-1 -: 8];
                n.body = r.body << 8;
                n.dval = 1'b1;
                n.bidx = r.bidx + 4'h1;
                if (r.bidx == BODY_LAST) begin
                    if (r.nfrm == '0) begin
                        n.dlast = 1'b1;
                        n.st = sdfb_pkg::ST_IDLE;
                    end else begin
                        // (RULE_02) entries right after module status
                        n.ptr = r.head[PW-1:0];
                        n.emitted = '0;
                        n.ph = sdfb_pkg::PH_WAIT;
                        n.st = sdfb_pkg::ST_ENT;
                    end
                end
            end
            sdfb_pkg::ST_ENT: begin
                case (r.ph)
                    sdfb_pkg::PH_WAIT: begin
                        n.ph = sdfb_pkg::PH_EVAL;
                    end
                    sdfb_pkg::PH_EVAL: begin
                        // (RULE_18) oldest pending entries first
                        if (r.vld[r.ptr]) begin
                            n.ent = mif.rdata;
                            n.bcnt = 2'h0;
                            n.ph = sdfb_pkg::PH_EMIT;
                        end else begin
                            n.ptr = r.ptr + 1'b1;
                            n.ph = sdfb_pkg::PH_WAIT;
                        end
                    end
                    default: begin
                        n.dout = r.ent[sdfb_pkg::ENTRY_W-1 -: 8];
                        n.ent = r.ent << 8;
                        n.dval = 1'b1;
                        n.bcnt = r.bcnt + 2'h1;
                        if (r.bcnt == ENT_LAST) begin
                            n.emitted = r.emitted + ONE;
                            n.ptr = r.ptr + 1'b1;
                            n.ph = sdfb_pkg::PH_WAIT;
                            // (RULE_04) stop at the capped count
                            if (r.emitted + ONE == r.nfrm) begin
                                n.dlast = 1'b1;
                                n.st = sdfb_pkg::ST_IDLE;
                            end
                        end
                    end
                endcase
            end
            default: begin
                n.st = sdfb_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            r <= '0;
            r.st <= sdfb_pkg::ST_IDLE;
        end else begin
            r <= n;
        end
    end

    assign FRAME_DATA = r.dout;
    assign FRAME_VALID = r.dval;
    assign FRAME_LAST = r.dlast;
    assign FRAME_LEN = r.len;
    assign STATION_STAT3 = r.stat3;
    assign PEND_COUNT = 8'(r.pend);
endmodule : sdfb_frame_builder

// File: sdfb_frame_builder_props.sv
// sdfb_frame_builder_props: port checks of the frame builder
// assumes one clock domain; bound to every sdfb_frame_builder
`timescale 1ns/10ps
module sdfb_frame_builder_props (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic DIAG_VALID,
    input wire logic DIAG_READY,
    input wire logic DIAG_CLEAR,
    input wire logic [23:0] IDENT_DIAG,
    input wire logic [63:0] MOD_STATUS,
    input wire logic FRAME_REQ,
    input wire logic FRAME_READY,
    input wire logic [7:0] FRAME_DATA,
    input wire logic FRAME_VALID,
    input wire logic FRAME_LAST,
    input wire logic [7:0] FRAME_LEN,
    input wire logic [7:0] STATION_STAT3,
    input wire logic [7:0] PEND_COUNT
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    logic take;
    assign take = FRAME_REQ && FRAME_READY;
    stat3_low_a: assert property (STATION_STAT3[6:0] == 7'h00)
        else $error("station status 3 low bits set");
    ovf_flag_a: assert property (STATION_STAT3[7] == ($past(PEND_COUNT) > 8'd26))
        else $error("overflow bit wrong");
    len_cap_a: assert property (FRAME_LEN <= 8'd96)
        else $error("frame too long");
    len_calc_a: assert property (take |=> FRAME_LEN == 8'd17 + 8'd3 *
        ($past(PEND_COUNT) > 8'd26 ? 8'd26 : $past(PEND_COUNT))) else $error("frame length wrong");
    body_run_a: assert property (take |-> ##1 !FRAME_VALID ##1 FRAME_VALID [*8] ##1 FRAME_VALID [*3])
        else $error("body bytes not consecutive");
    ident_pos_a: assert property (take |-> ##2 FRAME_DATA == $past(IDENT_DIAG[23:16], 2))
        else $error("identifier byte misplaced");
    mod_pos_a: assert property (take |-> ##5 FRAME_DATA == $past(MOD_STATUS[63:56], 5))
        else $error("module status misplaced");
    empty_end_a: assert property (take && PEND_COUNT == 8'd0 |-> ##12 FRAME_LAST ##1 FRAME_READY)
        else $error("empty frame end wrong");
    type_legal_a: assert property (FRAME_LAST && FRAME_LEN != 8'd17 |->
        FRAME_DATA[7:5] == 3'h0 && FRAME_DATA[4:0] inside {[5'h01:5'h09]}) else $error("bad error type");
    raise_count_a: assert property (DIAG_VALID && DIAG_READY && !DIAG_CLEAR |=>
        PEND_COUNT == $past(PEND_COUNT) + 8'h01) else $error("raise not counted");
    clear_busy_a: assert property (DIAG_VALID && DIAG_READY && DIAG_CLEAR |=> !DIAG_READY [*2])
        else $error("clear scan not blocking");
endmodule : sdfb_frame_builder_props
bind sdfb_frame_builder sdfb_frame_builder_props u_sdfb_frame_builder_props (.CORE_CLK, .RST_N,
    .DIAG_VALID, .DIAG_READY, .DIAG_CLEAR, .IDENT_DIAG, .MOD_STATUS, .FRAME_REQ, .FRAME_READY,
    .FRAME_DATA, .FRAME_VALID, .FRAME_LAST, .FRAME_LEN, .STATION_STAT3, .PEND_COUNT);

// File: sdfb_master_model.sv
// sdfb_master_model: reading master, asks for one frame and collects its bytes
// assumes go pulses from the bench; lag sets a slow or prompt request
`timescale 1ns/10ps
module sdfb_master_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [3:0] lag,
    input wire logic FRAME_READY,
    input wire logic [7:0] FRAME_DATA,
    input wire logic FRAME_VALID,
    input wire logic FRAME_LAST,
    output logic frame_req,
    output logic done,
    output logic [7:0] n_rx,
    output logic [7:0] rx [0:95]
);
    logic [3:0] wait_r;
    logic armed_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_req <= 1'b0;
            done <= 1'b0;
            n_rx <= 8'h00;
            wait_r <= 4'h0;
            armed_r <= 1'b0;
        end else begin
            done <= FRAME_VALID && FRAME_LAST;
            if (go) begin
                armed_r <= 1'b1;
                wait_r <= lag;
                n_rx <= 8'h00;
            end else if (armed_r && wait_r != 4'h0) begin
                wait_r <= wait_r - 4'h1;
            end else if (armed_r) begin
                frame_req <= 1'b1;
                armed_r <= 1'b0;
            end
            // request held until taken
            if (frame_req && FRAME_READY) frame_req <= 1'b0;
            if (FRAME_VALID && n_rx < 8'd96) begin
                rx[n_rx] <= FRAME_DATA;
                n_rx <= n_rx + 8'h01;
            end
        end
    end
endmodule : sdfb_master_model

// File: testbench.sv
// testbench: random and corner stimulus for the frame builder with a reading master
// assumes package, interface, store, builder, checker and master model compiled first
`timescale 1ns/10ps
module testbench;
    logic CORE_CLK = 1'b0, RST_N = 1'b0, DIAG_VALID = 1'b0, DIAG_CLEAR = 1'b0, DIAG_ALL_CH = 1'b0;
    logic FRAME_REQ, FRAME_READY, DIAG_READY, FRAME_VALID, FRAME_LAST, done, go = 1'b0;
    logic [7:0] DIAG_SLOT = 8'h00, DIAG_CHAN = 8'h00, FRAME_DATA, FRAME_LEN, STATION_STAT3, PEND_COUNT, n_rx;
    logic [3:0] DIAG_KIND = 4'h0, lag = 4'h0;
    logic [23:0] IDENT_DIAG = 24'h00_0000;
    logic [63:0] MOD_STATUS = 64'h0000_0000_0000_0000;
    logic [7:0] rx [0:95];
    logic [23:0] pend [$];
    int n_errors = 0, compares = 0, seed = 32'h5708_447d;
    always #25 CORE_CLK = ~CORE_CLK;
    sdfb_frame_builder #(.DEPTH(32)) u_sdfb_frame_builder (.CORE_CLK, .RST_N, .DIAG_VALID, .DIAG_READY,
        .DIAG_CLEAR, .DIAG_SLOT, .DIAG_CHAN, .DIAG_ALL_CH, .DIAG_KIND, .IDENT_DIAG, .MOD_STATUS, .FRAME_REQ,
        .FRAME_READY, .FRAME_DATA, .FRAME_VALID, .FRAME_LAST, .FRAME_LEN, .STATION_STAT3, .PEND_COUNT);
    sdfb_master_model u_sdfb_master_model (.clk(CORE_CLK), .rst_n(RST_N), .go, .lag, .FRAME_READY,
        .FRAME_DATA, .FRAME_VALID, .FRAME_LAST, .frame_req(FRAME_REQ), .done, .n_rx, .rx);
    task automatic test_done();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    function automatic logic [4:0] code(input logic [3:0] kind);
        return (kind <= 4'h8) ? {1'b0, kind} + 5'h01 : 5'h09;
    endfunction : code
    task automatic wait_ready();
        int n;
        n = 0;
        do begin @(negedge CORE_CLK); n++; end while (DIAG_READY !== 1'b1 && n < 300);
        if (n >= 300) n_errors++;
        @(posedge CORE_CLK);
    endtask : wait_ready
    task automatic diag(input logic clr, input logic [7:0] slot, chan, input logic all, input logic [3:0] kind);
        DIAG_VALID <= 1'b1;
        DIAG_CLEAR <= clr;
        DIAG_SLOT <= slot;
        DIAG_CHAN <= chan;
        DIAG_ALL_CH <= all;
        DIAG_KIND <= kind;
        wait_ready();
        if (clr) begin
            DIAG_VALID <= 1'b0;
            wait_ready();
        end
    endtask : diag
    task automatic raise(input logic [7:0] slot, chan, input logic all, input logic [3:0] kind);
        diag(1'b0, slot, chan, all, kind);
        pend.push_back({slot, all ? 8'h00 : chan, 3'b000, code(kind)});
    endtask : raise
    task automatic clr_at(input int i);
        logic [23:0] e;
        e = pend[i];
        diag(1'b1, e[23:16], e[15:8], 1'b0, 4'(e[4:0] - 5'h01));
        pend.delete(i);
    endtask : clr_at
    task automatic frame();
        int k, m;
        DIAG_VALID <= 1'b0;
        IDENT_DIAG <= 24'($random(seed));
        MOD_STATUS <= {$random(seed), $random(seed)};
        lag <= 4'($random(seed));
        go <= 1'b1;
        @(posedge CORE_CLK);
        go <= 1'b0;
        k = 0;
        do begin @(negedge CORE_CLK); k++; end while (done !== 1'b1 && k < 400);
        if (done !== 1'b1) n_errors++;
        m = pend.size() > 26 ? 26 : pend.size();
        chk8(n_rx, 8'(11 + 3 * m));
        for (k = 0; k < 3; k++) chk8(rx[k], IDENT_DIAG[23 - 8 * k -: 8]);
        for (k = 0; k < 8; k++) chk8(rx[3 + k], MOD_STATUS[63 - 8 * k -: 8]);
        for (k = 0; k < 3 * m; k++) chk8(rx[11 + k], pend[k / 3][23 - 8 * (k % 3) -: 8]);
        chk8(FRAME_LEN, 8'(17 + 3 * m));
        chk8(STATION_STAT3, pend.size() > 26 ? 8'h80 : 8'h00);
        chk8(PEND_COUNT, 8'(pend.size()));
        @(posedge CORE_CLK);
    endtask : frame
    initial begin
        repeat (20) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        @(posedge CORE_CLK);
        frame();
        for (int k = 0; k < 16; k++) raise(8'(k), 8'($random(seed)), k == 3, 4'(k));
        frame();
        for (int k = 16; k < 30; k++) raise(8'(k), 8'($random(seed)), 1'b0, 4'($random(seed)));
        frame();
        clr_at(0);
        diag(1'b1, 8'hff, 8'h00, 1'b0, 4'h0);
        frame();
        clr_at(3);
        clr_at(20);
        frame();
        clr_at(0);
        frame();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        n_errors++;
        test_done();
    end
endmodule : testbench
